// ===== hdl/afecr_pkg.sv
package afecr_pkg;

    // ----------------------------------------------------------------
    // bus and register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFS_CUR_MAG = 8'h0e;
    localparam logic [7:0] OFS_RSVD_ZERO = 8'h0f;
    localparam logic [7:0] OFS_AMP_CFG = 8'h10;
    localparam logic [7:0] OFS_IN_SEL = 8'h11;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_CUR_MAG = 8'h00;
    localparam logic [7:0] RST_AMP_CFG = 8'h00;
    localparam logic [7:0] RST_IN_SEL = 8'hff;
    localparam logic [7:0] RSVD_READ = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SRC2_MSB = 7;
    localparam int SRC2_LSB = 4;
    localparam int SRC1_MSB = 3;
    localparam int SRC1_LSB = 0;
    localparam int BYPASS_BIT = 7;
    localparam int AMP_RSVD_MSB = 6;
    localparam int AMP_RSVD_LSB = 3;
    localparam int GAIN_MSB = 2;
    localparam int GAIN_LSB = 0;
    localparam int POS_MSB = 7;
    localparam int POS_LSB = 4;
    localparam int NEG_MSB = 3;
    localparam int NEG_LSB = 0;

    // ----------------------------------------------------------------
    // field codes
    // ----------------------------------------------------------------
    localparam logic [3:0] MAG_MAX_CODE = 4'ha;
    localparam logic [3:0] SEL_COMMON_PIN = 4'h0;
    localparam logic [3:0] SEL_AIN_FIRST = 4'h1;
    localparam logic [3:0] SEL_AIN_LAST = 4'ha;
    localparam logic [3:0] SEL_TEMP = 4'hb;
    localparam logic [3:0] SEL_AVDD_QTR = 4'hc;
    localparam logic [3:0] SEL_DVDD_QTR = 4'hd;
    localparam logic [3:0] SEL_OPEN = 4'he;
    localparam logic [3:0] SEL_MIDPOINT = 4'hf;

    // source magnitude in microamps, off as zero
    localparam logic [11:0] UA_TABLE [0:10] = '{
        12'h000, 12'h032, 12'h064, 12'h0fa, 12'h1f4, 12'h2ee,
        12'h3e8, 12'h5dc, 12'h7d0, 12'h9c4, 12'hbb8
    };

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        AFECR_SRC_COMMON,
        AFECR_SRC_AIN,
        AFECR_SRC_TEMP,
        AFECR_SRC_AVDD_QTR,
        AFECR_SRC_DVDD_QTR,
        AFECR_SRC_OPEN,
        AFECR_SRC_MIDPOINT
    } afecr_src_t;

    typedef struct packed {
        afecr_src_t kind;
        logic [3:0] ain_index;
    } afecr_route_t;

    typedef struct packed {
        logic first_source_on;
        logic [11:0] first_source_ua;
        logic second_source_on;
        logic [11:0] second_source_ua;
    } afecr_excite_t;

    typedef struct packed {
        logic amp_bypass;
        logic [2:0] gain_code;
        logic [7:0] gain_factor;
    } afecr_amp_t;

endpackage

// ===== hdl/afecr_regs.sv
// What this block does
// - upper nibble at 0Eh sets second source; codes above 1010 mean off
// - lower nibble at 0Eh sets first source, same code table
// - magnitude register at 0Eh is read/write and resets to 00h
// - address 0Fh is read-only and always reads all zeros
// - bit 7 at 10h: 0 keeps amplifier in path, 1 bypasses it
// - amplifier register 10h resets 00h; bits 2:0 pick gain 1 to 128
// - upper nibble at 11h picks positive converter input
// - lower nibble at 11h picks negative input, same code table
// - selector register at 11h resets to FFh, both inputs at midpoint
//
// The plain strobed port is this design's own decision.
module afecr_regs
    import afecr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [afecr_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [afecr_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [afecr_pkg::DATA_W-1:0] reg_rdata,
    output afecr_pkg::afecr_excite_t excite,
    output afecr_pkg::afecr_amp_t amp,
    output afecr_pkg::afecr_route_t positive_input_select,
    output afecr_pkg::afecr_route_t negative_input_select,
    output logic amp_reserved_nonzero
);
    import afecr_pkg::*;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // the logic below hard-codes byte-wide registers and nibble fields
    if (DATA_W != 8) begin : g_bad_data_w
        $error("register data width must be 8");
    end

    if (ADDR_W != 8) begin : g_bad_addr_w
        $error("register address width must be 8");
    end

    if (SRC2_MSB - SRC2_LSB != 3) begin : g_bad_src2
        $error("second source field must be four bits");
    end

    if (SRC1_MSB - SRC1_LSB != 3) begin : g_bad_src1
        $error("first source field must be four bits");
    end

    if (POS_MSB - POS_LSB != 3) begin : g_bad_pos
        $error("positive select field must be four bits");
    end

    if (NEG_MSB - NEG_LSB != 3) begin : g_bad_neg
        $error("negative select field must be four bits");
    end

    if (GAIN_MSB - GAIN_LSB != 2) begin : g_bad_gain
        $error("gain field must be three bits");
    end

    if (MAG_MAX_CODE > 4'ha) begin : g_bad_mag
        $error("magnitude table holds eleven entries");
    end

    if (BYPASS_BIT >= DATA_W) begin : g_bad_bypass
        $error("bypass bit lies outside the register");
    end

    // overlapping fields would let one write change two settings
    if (SRC1_MSB >= SRC2_LSB) begin : g_src_overlap
        $error("source fields overlap");
    end

    if (NEG_MSB >= POS_LSB) begin : g_sel_overlap
        $error("select fields overlap");
    end

    if (GAIN_MSB >= AMP_RSVD_LSB || AMP_RSVD_MSB >= BYPASS_BIT)
    begin : g_amp_overlap
        $error("amplifier fields overlap");
    end

    if (OFS_CUR_MAG == OFS_AMP_CFG || OFS_AMP_CFG == OFS_IN_SEL ||
        OFS_CUR_MAG == OFS_IN_SEL) begin : g_ofs_clash
        $error("register offsets must differ");
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        AFECR_TGT_NONE,
        AFECR_TGT_MAG,
        AFECR_TGT_RSVD,
        AFECR_TGT_AMP,
        AFECR_TGT_SEL
    } afecr_target_t;

    // codes above the table mean off, not the largest current
    function automatic logic mag_in_range(input logic [3:0] code);
        return code <= MAG_MAX_CODE;
    endfunction

    // explicit cases keep the off codes visible next to the live ones
    function automatic logic [11:0] mag_ua(input logic [3:0] code);
        logic [11:0] ua;
        ua = 12'h000;
        case (code)
            4'h0: ua = UA_TABLE[0];
            4'h1: ua = UA_TABLE[1];
            4'h2: ua = UA_TABLE[2];
            4'h3: ua = UA_TABLE[3];
            4'h4: ua = UA_TABLE[4];
            4'h5: ua = UA_TABLE[5];
            4'h6: ua = UA_TABLE[6];
            4'h7: ua = UA_TABLE[7];
            4'h8: ua = UA_TABLE[8];
            4'h9: ua = UA_TABLE[9];
            4'ha: ua = UA_TABLE[10];
            4'hb: ua = 12'h000;
            4'hc: ua = 12'h000;
            4'hd: ua = 12'h000;
            4'he: ua = 12'h000;
            4'hf: ua = 12'h000;
            default: ua = 12'h000;
        endcase
        return ua;
    endfunction

    // gain is a power of two; the bypass bit does not change it
    function automatic logic [7:0] gain_of(input logic [2:0] code);
        logic [7:0] f;
        f = 8'h01;
        case (code)
            3'h0: f = 8'h01;
            3'h1: f = 8'h02;
            3'h2: f = 8'h04;
            3'h3: f = 8'h08;
            3'h4: f = 8'h10;
            3'h5: f = 8'h20;
            3'h6: f = 8'h40;
            3'h7: f = 8'h80;
            default: f = 8'h01;
        endcase
        return f;
    endfunction

    // codes 1 to 10 are analog inputs 0 to 9
    function automatic afecr_route_t route_of(input logic [3:0] code);
        afecr_route_t r;
        r.kind = AFECR_SRC_MIDPOINT;
        r.ain_index = 4'h0;
        case (code)
            SEL_COMMON_PIN: begin
                r.kind = AFECR_SRC_COMMON;
            end

            SEL_AIN_FIRST: begin
                r.kind = AFECR_SRC_AIN;
                r.ain_index = 4'h0;
            end
            4'h2: begin
                r.kind = AFECR_SRC_AIN;
                r.ain_index = 4'h1;
            end
            4'h3: begin
                r.kind = AFECR_SRC_AIN;
                r.ain_index = 4'h2;
            end
            4'h4: begin
                r.kind = AFECR_SRC_AIN;
                r.ain_index = 4'h3;
            end
            4'h5: begin
                r.kind = AFECR_SRC_AIN;
                r.ain_index = 4'h4;
            end
            4'h6: begin
                r.kind = AFECR_SRC_AIN;
                r.ain_index = 4'h5;
            end
            4'h7: begin
                r.kind = AFECR_SRC_AIN;
                r.ain_index = 4'h6;
            end
            4'h8: begin
                r.kind = AFECR_SRC_AIN;
                r.ain_index = 4'h7;
            end
            4'h9: begin
                r.kind = AFECR_SRC_AIN;
                r.ain_index = 4'h8;
            end
            SEL_AIN_LAST: begin
                r.kind = AFECR_SRC_AIN;
                r.ain_index = 4'h9;
            end

            // internal sources: each side takes its own pole
            SEL_TEMP: begin
                r.kind = AFECR_SRC_TEMP;
            end
            SEL_AVDD_QTR: begin
                r.kind = AFECR_SRC_AVDD_QTR;
            end
            SEL_DVDD_QTR: begin
                r.kind = AFECR_SRC_DVDD_QTR;
            end
            SEL_OPEN: begin
                r.kind = AFECR_SRC_OPEN;
            end
            SEL_MIDPOINT: begin
                r.kind = AFECR_SRC_MIDPOINT;
            end
            default: begin
                r.kind = AFECR_SRC_MIDPOINT;
            end
        endcase
        return r;
    endfunction

    // one target per address keeps write and read decode in step
    function automatic afecr_target_t target_of(input logic [7:0] addr);
        afecr_target_t t;
        t = AFECR_TGT_NONE;
        case (addr)
            OFS_CUR_MAG: t = AFECR_TGT_MAG;
            OFS_RSVD_ZERO: t = AFECR_TGT_RSVD;
            OFS_AMP_CFG: t = AFECR_TGT_AMP;
            OFS_IN_SEL: t = AFECR_TGT_SEL;
            default: t = AFECR_TGT_NONE;
        endcase
        return t;
    endfunction

    // unmapped addresses and 0Fh read as zero
    function automatic logic [7:0] read_value(
        input afecr_target_t tgt,
        input logic [7:0] mag,
        input logic [7:0] ampc,
        input logic [7:0] sel
    );
        logic [7:0] v;
        v = RSVD_READ;
        case (tgt)
            AFECR_TGT_MAG: v = mag;
            AFECR_TGT_RSVD: v = RSVD_READ;
            AFECR_TGT_AMP: v = ampc;
            AFECR_TGT_SEL: v = sel;
            default: v = RSVD_READ;
        endcase
        return v;
    endfunction

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic [7:0] cur_mag_reg;
    logic [7:0] amp_cfg_reg;
    logic [7:0] in_sel_reg;
    logic [7:0] rdata_next;
    logic [7:0] rdata_reg;
    afecr_target_t bus_target;

    assign bus_target = target_of(reg_addr);
    wire logic hit_cur = bus_target == AFECR_TGT_MAG;
    wire logic hit_amp = bus_target == AFECR_TGT_AMP;
    wire logic hit_sel = bus_target == AFECR_TGT_SEL;

    // 0Fh has no write enable at all, so a write there changes nothing
    wire logic wr_cur = reg_wr && hit_cur;
    wire logic wr_amp = reg_wr && hit_amp;
    wire logic wr_sel = reg_wr && hit_sel;

    assign rdata_next = read_value(bus_target, cur_mag_reg, amp_cfg_reg,
        in_sel_reg);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    // both sources change together on one write
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cur_mag_reg <= RST_CUR_MAG;
        end else if (wr_cur) begin
            cur_mag_reg <= reg_wdata;
        end
    end

    // reserved bits stored as written so software sees them
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            amp_cfg_reg <= RST_AMP_CFG;
        end else if (wr_amp) begin
            amp_cfg_reg <= reg_wdata;
        end
    end

    // selector resets to the midpoint on both sides
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            in_sel_reg <= RST_IN_SEL;
        end else if (wr_sel) begin
            in_sel_reg <= reg_wdata;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign reg_rdata = rdata_reg;

    // ----------------------------------------------------------------
    // field outputs
    // ----------------------------------------------------------------
    wire logic [3:0] src2_code = cur_mag_reg[SRC2_MSB:SRC2_LSB];
    wire logic [3:0] src1_code = cur_mag_reg[SRC1_MSB:SRC1_LSB];
    wire logic [2:0] gain_code = amp_cfg_reg[GAIN_MSB:GAIN_LSB];
    wire logic [3:0] pos_code = in_sel_reg[POS_MSB:POS_LSB];
    wire logic [3:0] neg_code = in_sel_reg[NEG_MSB:NEG_LSB];
    wire logic [3:0] amp_rsvd = amp_cfg_reg[AMP_RSVD_MSB:AMP_RSVD_LSB];

    // on follows the code, so every off code reads as off
    wire logic src2_on = mag_in_range(src2_code) && src2_code != 4'h0;
    wire logic src1_on = mag_in_range(src1_code) && src1_code != 4'h0;

    assign excite.second_source_ua = mag_ua(src2_code);
    assign excite.second_source_on = src2_on;
    assign excite.first_source_ua = mag_ua(src1_code);
    assign excite.first_source_on = src1_on;

    assign amp.amp_bypass = amp_cfg_reg[BYPASS_BIT];
    assign amp.gain_code = gain_code;
    assign amp.gain_factor = gain_of(gain_code);
    // flags software that broke the write-zero convention
    assign amp_reserved_nonzero = |amp_rsvd;

    assign positive_input_select = route_of(pos_code);
    assign negative_input_select = route_of(neg_code);

endmodule

// ===== tb/afecr_checker.sv
module afecr_checker
    import afecr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire afecr_excite_t excite,
    input wire afecr_amp_t amp,
    input wire afecr_route_t positive_input_select,
    input wire afecr_route_t negative_input_select,
    input wire logic amp_reserved_nonzero
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------
    // write effects and reserved read
    // ------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire w_mag = reg_wr && reg_addr == 8'h0e;
    wire w_amp = reg_wr && reg_addr == 8'h10;
    wire w_sel = reg_wr && reg_addr == 8'h11;
    wire w_rsv = reg_wr && reg_addr == 8'h0f;
    chk_src2_code: assert property (
        w_mag |=> excite.second_source_on ==
        ($past(reg_wdata[7:4]) inside {[1:10]})) else $error("src2 on");
    chk_src1_code: assert property (
        w_mag |=> excite.first_source_on ==
        ($past(reg_wdata[3:0]) inside {[1:10]})) else $error("src1 on");
    chk_bypass_bit: assert property (
        w_amp |=> amp.amp_bypass == $past(reg_wdata[7])) else $error("bypass");
    chk_gain_factor: assert property (
        w_amp |=> amp.gain_factor == 8'h01 << $past(reg_wdata[2:0]))
        else $error("gain");
    chk_pos_ain: assert property (
        w_sel && reg_wdata[7:4] inside {[1:10]} |=>
        positive_input_select.ain_index == $past(reg_wdata[7:4]) - 4'h1)
        else $error("pos index");
    chk_neg_ain: assert property (
        w_sel && reg_wdata[3:0] inside {[1:10]} |=>
        negative_input_select.ain_index == $past(reg_wdata[3:0]) - 4'h1)
        else $error("neg index");
    chk_rsvd_read: assert property (
        reg_rd && reg_addr == 8'h0f |=> reg_rdata == 8'h00)
        else $error("reserved read");
    chk_rsvd_ignored: assert property (
        w_rsv |=> $stable(excite) && $stable(amp)) else $error("reserved wr");
endmodule

// ===== tb/afecr_regs_test.sv
module afecr_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import afecr_pkg::*;
    // ------------------------------------------------
    // stimulus and checks
    // ------------------------------------------------
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    afecr_excite_t excite;
    afecr_amp_t amp;
    afecr_route_t positive_input_select;
    afecr_route_t negative_input_select;
    logic amp_reserved_nonzero;
    int n_errors = 0;
    int tests_run = 0;
    int ua [16] = '{0, 50, 100, 250, 500, 750, 1000, 1500, 2000, 2500,
        3000, 0, 0, 0, 0, 0};
    always #5 clk = ~clk;
    afecr_regs u_dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .excite, .amp, .positive_input_select,
        .negative_input_select, .amp_reserved_nonzero);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(16'(reg_rdata), 16'(exp));
    endtask
    // enum order: common, ain, temp, avdd, dvdd, open, midpoint
    function automatic logic [15:0] kind_of(input int c);
        return (c == 0) ? 16'h0000 : (c < 11) ? 16'h0001 : 16'(c - 9);
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rd(8'h0e, 8'h00);
        rd(8'h10, 8'h00);
        rd(8'h11, 8'hff);
        chk(16'(negative_input_select.kind), 16'h0006);
        chk(16'(positive_input_select.kind), 16'h0006);
        for (int i = 0; i < 16; i++) begin
            wr(8'h0e, {4'(i), 4'(15 - i)});
            chk(16'(excite.second_source_ua), 16'(ua[i]));
            chk(16'(excite.first_source_ua), 16'(ua[15 - i]));
            rd(8'h0e, {4'(i), 4'(15 - i)});
            wr(8'h11, {4'(i), 4'(15 - i)});
            chk(16'(positive_input_select.kind), kind_of(i));
            chk(16'(negative_input_select.kind), kind_of(15 - i));
        end
        for (int g = 0; g < 8; g++) begin
            wr(8'h10, {g[0], 4'h0, 3'(g)});
            chk(16'(amp.gain_factor), 16'(1 << g));
            chk(16'(amp.amp_bypass), 16'(g[0]));
            chk(16'(amp_reserved_nonzero), 16'h0000);
        end
        wr(8'h10, 8'h78);
        chk(16'(amp_reserved_nonzero), 16'h0001);
        wr(8'h0f, 8'ha5);
        rd(8'h0f, 8'h00);
        rd(8'h0e, 8'hf0);
        rd(8'h10, 8'h78);
        rd(8'h20, 8'h00);
        tally_and_finish();
    end
    // whole run is about 140 cycles
    initial begin
        #20000;
        n_errors++;
        tally_and_finish();
    end
endmodule
bind afecr_regs afecr_checker u_chk (.clk, .rst_b, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .excite, .amp, .positive_input_select,
    .negative_input_select, .amp_reserved_nonzero);
